// ==== rtl/trs_pkg.sv ====
// Constants, types and encodings shared by the trap and return sequencer
package trs_pkg;
  // Opcode match values and masks
  localparam logic [15:0] RTS_MASK   = 16'hFFF8;
  localparam logic [15:0] RTS_CODE   = 16'h0080;
  localparam logic [15:0] MARK_MASK  = 16'hFFC0;
  localparam logic [15:0] MARK_CODE  = 16'h0D00;
  localparam logic [15:0] SOB_MASK   = 16'hFE00;
  localparam logic [15:0] SOB_CODE   = 16'h7E00;
  localparam logic [15:0] SPL_MASK   = 16'hFFF8;
  localparam logic [15:0] SPL_CODE   = 16'h0098;
  localparam logic [15:0] SWT_MASK   = 16'hFF00;
  localparam logic [15:0] EMT_CODE   = 16'h8800;
  localparam logic [15:0] TRAP_CODE  = 16'h8900;
  localparam logic [15:0] BPT_CODE   = 16'h0003;
  localparam logic [15:0] IOT_CODE   = 16'h0004;
  localparam logic [15:0] RTI_CODE   = 16'h0002;
  localparam logic [15:0] RTT_CODE   = 16'h0006;
  localparam logic [15:0] JMP_MASK   = 16'hFFC0;
  localparam logic [15:0] JMP_CODE   = 16'h0040;
  localparam logic [15:0] JSR_MASK   = 16'hFE00;
  localparam logic [15:0] JSR_CODE   = 16'h0800;
  // Trap vector locations (byte addresses)
  localparam logic [15:0] VEC_BUSERR = 16'h0004;
  localparam logic [15:0] VEC_RESVD  = 16'h0008;
  localparam logic [15:0] VEC_BPT    = 16'h000C;
  localparam logic [15:0] VEC_IOT    = 16'h0010;
  localparam logic [15:0] VEC_PWR    = 16'h0014;
  localparam logic [15:0] VEC_EMT    = 16'h0018;
  localparam logic [15:0] VEC_TRAP   = 16'h001C;
  localparam logic [15:0] WORD_STEP  = 16'h0002;
  // Status word fields
  localparam int          PS_T_BIT   = 4;
  localparam int          PS_PRI_LO  = 5;
  localparam int          PS_PRI_HI  = 7;
  localparam int          PS_MODE_LO = 14;
  localparam int          PS_MODE_HI = 15;
  // Register indices
  localparam logic [2:0]  LINK_IDX   = 3'h5;
  localparam logic [2:0]  SP_IDX     = 3'h6;
  localparam logic [2:0]  PC_IDX     = 3'h7;
  // Reset values
  localparam logic [15:0] GPR_RESET  = 16'h0000;
  localparam logic [15:0] PS_RESET   = 16'h0000;
  // Bus timeout, in processor clock cycles
  localparam int          BUS_TIMEOUT_CYCLES = 64;
  // APB register map and control fields
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PC     = 12'h008;
  localparam logic [11:0] ADDR_PS     = 12'h00C;
  localparam int          CTRL_RUN    = 0;
  localparam int          CTRL_CONT   = 1;

  typedef enum logic [3:0] {
    OPC_RTS, OPC_MARK, OPC_SOB, OPC_SPL, OPC_SWTRAP,
    OPC_RTI, OPC_RTT, OPC_ILLEGAL, OPC_EXT
  } trs_opclass_t;

  typedef enum logic [4:0] {
    S_IDLE, S_FETCH, S_MEM, S_DECODE, S_EXT, S_POP_REG, S_RET_PC, S_RET_PS,
    S_END, S_PUSH_PS, S_PUSH_PC, S_VEC_PC, S_VEC_PS, S_TRAP_DONE, S_HALT
  } trs_state_t;

  typedef struct packed {
    trs_opclass_t opclass;
    logic [15:0]  vector;
  } trs_decode_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } trs_mem_req_t;
endpackage : trs_pkg

// ==== rtl/trs_sequencer.sv ====
// Trap and return sequencer: returns, loop branch, priority, traps and trace
//
// Operation
// - Subroutine return: register to PC, then pop stack into that register.
// - Frame unwind: SP = PC + 2n, PC = R5, pop R5; flags kept.
// - Loop branch: decrement register; if nonzero, PC minus twice offset.
// - Loop branch offset is unsigned six bits, so never forward.
// - Set priority copies low three instruction bits into status 7-5, only when status bits 15-14 are zero.
// - Trap pushes status then PC, then loads PC and status from vector.
// - Opcodes 104000-104377 are emulator trap through vector 30.
// - Emulator trap takes new status with flags from location 32.
// - Opcodes 104400-104777 are general trap through vector 34.
// - Breakpoint code 000003 traps through vector 14.
// - I/O trap loads PC from 20 and status from 22.
// - Return from interrupt pops PC then status, restoring all flags.
// - Trace-inhibiting return lets one more instruction run before trace.
// - Ordinary return leaving trace bit set traps at once.
// - Undefined opcodes trap through 10, illegal modes through 4.
// - Jump or call with register-mode destination is illegal.
// - Odd address fetch or word access aborts with a bus error.
// - Unanswered bus access times out; both bus errors use vector 4.
// - With trace bit set, the next instruction completes then traps via 14.
// - Priority: odd address, timeout, trap instruction, trace, power fail.
// - Bus error during a trap sequence halts the processor.
// - Trace dropped if a traced return loads status with the bit clear.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module trs_sequencer #(
  parameter int BUS_TIMEOUT = trs_pkg::BUS_TIMEOUT_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output logic                       pready,
  output var  logic                  pslverr,
  // Memory bus master
  output var  trs_pkg::trs_mem_req_t mem_out,
  input  wire logic                  mem_ack,
  input  wire logic [15:0]           mem_rdata,
  // Hand-off of other instructions to the rest of the core
  output logic                       ext_valid,
  output logic [15:0]                ext_instr,
  input  wire logic                  ext_ready,
  input  wire logic                  ext_undefined,
  // Power failure request and halt indication
  input  wire logic                  pwr_fail,
  output logic                       halted
);

  trs_pkg::trs_state_t   state_reg;
  trs_pkg::trs_state_t   ret_reg;
  logic [15:0]           gpr [0:7];
  logic [15:0]           ps_reg;
  logic [15:0]           instr_reg;
  logic [15:0]           mdata_reg;
  logic [15:0]           vec_reg;
  logic [15:0]           last_vec_reg;
  logic [2:0]            pop_dst_reg;
  logic                  in_trap_reg;
  logic                  trace_pend_reg;
  logic                  pf_pend_reg;
  logic                  pf_last_reg;
  logic                  run_reg;
  logic                  cont_reg;
  logic                  pc_wr_reg;
  logic [15:0]           pc_wdata_reg;
  logic [15:0]           tmo_cnt_reg;
  logic                  bus_timeout;
  logic                  pf_rise;
  trs_pkg::trs_decode_t  dec;
  logic [15:0]           pc_adv;
  logic [15:0]           sob_val;
  logic [15:0]           mark_sp;

  // Classify an instruction word and pick its trap vector
  function automatic trs_pkg::trs_decode_t decode_op(input logic [15:0] w);
    trs_pkg::trs_decode_t d;
    d.opclass = trs_pkg::OPC_EXT;
    d.vector  = trs_pkg::VEC_RESVD;
    if ((w & trs_pkg::RTS_MASK) == trs_pkg::RTS_CODE) begin
      d.opclass = trs_pkg::OPC_RTS;
    end else if ((w & trs_pkg::MARK_MASK) == trs_pkg::MARK_CODE) begin
      d.opclass = trs_pkg::OPC_MARK;
    end else if ((w & trs_pkg::SOB_MASK) == trs_pkg::SOB_CODE) begin
      d.opclass = trs_pkg::OPC_SOB;
    end else if ((w & trs_pkg::SPL_MASK) == trs_pkg::SPL_CODE) begin
      d.opclass = trs_pkg::OPC_SPL;
    end else if ((w & trs_pkg::SWT_MASK) == trs_pkg::EMT_CODE) begin
      d = '{trs_pkg::OPC_SWTRAP, trs_pkg::VEC_EMT};
    end else if ((w & trs_pkg::SWT_MASK) == trs_pkg::TRAP_CODE) begin
      d = '{trs_pkg::OPC_SWTRAP, trs_pkg::VEC_TRAP};
    end else if (w == trs_pkg::BPT_CODE) begin
      d = '{trs_pkg::OPC_SWTRAP, trs_pkg::VEC_BPT};
    end else if (w == trs_pkg::IOT_CODE) begin
      d = '{trs_pkg::OPC_SWTRAP, trs_pkg::VEC_IOT};
    end else if (w == trs_pkg::RTI_CODE) begin
      d.opclass = trs_pkg::OPC_RTI;
    end else if (w == trs_pkg::RTT_CODE) begin
      d.opclass = trs_pkg::OPC_RTT;
    end else if ((((w & trs_pkg::JMP_MASK) == trs_pkg::JMP_CODE) ||
                  ((w & trs_pkg::JSR_MASK) == trs_pkg::JSR_CODE)) && (w[5:3] == 3'h0)) begin
      d = '{trs_pkg::OPC_ILLEGAL, trs_pkg::VEC_BUSERR};
    end
    return d;
  endfunction : decode_op

  // Bus request builders; an odd address never raises the request
  function automatic trs_pkg::trs_mem_req_t rd_req(input logic [15:0] a);
    return '{req: ~a[0], we: 1'b0, addr: a, wdata: 16'h0000};
  endfunction : rd_req

  function automatic trs_pkg::trs_mem_req_t wr_req(input logic [15:0] a, input logic [15:0] d);
    return '{req: ~a[0], we: 1'b1, addr: a, wdata: d};
  endfunction : wr_req

  // Decode and arithmetic on the freshly fetched word
  assign dec     = decode_op(mdata_reg);
  assign pc_adv  = gpr[trs_pkg::PC_IDX] + trs_pkg::WORD_STEP;
  assign sob_val = gpr[mdata_reg[8:6]] - 16'h0001;
  assign mark_sp = pc_adv + {9'h000, mdata_reg[5:0], 1'b0};

  assign ext_valid = (state_reg == trs_pkg::S_EXT);
  assign ext_instr = instr_reg;
  assign halted    = (state_reg == trs_pkg::S_HALT);
  assign pready    = 1'b1;
  assign pf_rise   = pwr_fail & ~pf_last_reg;

  // Bus timeout counter, restarted by every response or idle bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt_reg <= 16'h0000;
    end else if (!mem_out.req || mem_ack) begin
      tmo_cnt_reg <= 16'h0000;
    end else begin
      tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
    end
  end

  assign bus_timeout = mem_out.req && !mem_ack &&
                       (tmo_cnt_reg == 16'(BUS_TIMEOUT - 1));

  // APB register file: run control, continue pulse and PC preset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg      <= 1'b0;
      cont_reg     <= 1'b0;
      pc_wr_reg    <= 1'b0;
      pc_wdata_reg <= 16'h0000;
    end else begin
      cont_reg  <= 1'b0;
      pc_wr_reg <= 1'b0;
      if (psel && penable && pwrite) begin
        if (paddr == trs_pkg::ADDR_CTRL) begin
          run_reg  <= pwdata[trs_pkg::CTRL_RUN];
          cont_reg <= pwdata[trs_pkg::CTRL_CONT];
        end
        if (paddr == trs_pkg::ADDR_PC) begin
          pc_wr_reg    <= 1'b1;
          pc_wdata_reg <= pwdata[15:0];
        end
      end
    end
  end

  // APB read data and error, prepared in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        trs_pkg::ADDR_CTRL:   prdata <= {30'h0000_0000, 1'b0, run_reg};
        trs_pkg::ADDR_STATUS: prdata <= {16'h0000, halted, in_trap_reg, trace_pend_reg,
                                         pf_pend_reg, 4'h0, last_vec_reg[7:0]};
        trs_pkg::ADDR_PC:     prdata <= {16'h0000, gpr[trs_pkg::PC_IDX]};
        trs_pkg::ADDR_PS:     prdata <= {16'h0000, ps_reg};
        default: begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Instruction sequencer with register file, status word and bus master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= trs_pkg::S_IDLE;
      ret_reg        <= trs_pkg::S_IDLE;
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= trs_pkg::GPR_RESET;
      end
      ps_reg         <= trs_pkg::PS_RESET;
      instr_reg      <= 16'h0000;
      mdata_reg      <= 16'h0000;
      vec_reg        <= 16'h0000;
      last_vec_reg   <= 16'h0000;
      pop_dst_reg    <= 3'h0;
      in_trap_reg    <= 1'b0;
      trace_pend_reg <= 1'b0;
      pf_pend_reg    <= 1'b0;
      pf_last_reg    <= 1'b0;
      mem_out        <= '0;
    end else begin
      pf_last_reg <= pwr_fail;
      case (state_reg)
        trs_pkg::S_IDLE: begin
          if (pc_wr_reg) begin
            gpr[trs_pkg::PC_IDX] <= pc_wdata_reg;
          end
          if (run_reg) begin
            state_reg <= trs_pkg::S_FETCH;
          end
        end
        trs_pkg::S_FETCH: begin
          trace_pend_reg <= ps_reg[trs_pkg::PS_T_BIT];
          mem_out        <= rd_req(gpr[trs_pkg::PC_IDX]);
          ret_reg        <= trs_pkg::S_DECODE;
          state_reg      <= trs_pkg::S_MEM;
        end
        trs_pkg::S_MEM: begin
          if (mem_out.addr[0] || bus_timeout) begin
            // Odd address is caught first, before any bus request
            mem_out.req <= 1'b0;
            if (in_trap_reg) begin
              state_reg <= trs_pkg::S_HALT;
            end else begin
              vec_reg        <= trs_pkg::VEC_BUSERR;
              last_vec_reg   <= trs_pkg::VEC_BUSERR;
              in_trap_reg    <= 1'b1;
              trace_pend_reg <= 1'b0;
              state_reg      <= trs_pkg::S_PUSH_PS;
            end
          end else if (mem_ack) begin
            mem_out.req <= 1'b0;
            mdata_reg   <= mem_rdata;
            state_reg   <= ret_reg;
          end
        end
        trs_pkg::S_DECODE: begin
          instr_reg            <= mdata_reg;
          gpr[trs_pkg::PC_IDX] <= pc_adv;
          state_reg            <= trs_pkg::S_END;
          case (dec.opclass)
            trs_pkg::OPC_RTS: begin
              gpr[trs_pkg::PC_IDX] <= gpr[mdata_reg[2:0]];
              pop_dst_reg          <= mdata_reg[2:0];
              mem_out              <= rd_req(gpr[trs_pkg::SP_IDX]);
              ret_reg              <= trs_pkg::S_POP_REG;
              state_reg            <= trs_pkg::S_MEM;
            end
            trs_pkg::OPC_MARK: begin
              gpr[trs_pkg::SP_IDX] <= mark_sp;
              gpr[trs_pkg::PC_IDX] <= gpr[trs_pkg::LINK_IDX];
              pop_dst_reg          <= trs_pkg::LINK_IDX;
              mem_out              <= rd_req(mark_sp);
              ret_reg              <= trs_pkg::S_POP_REG;
              state_reg            <= trs_pkg::S_MEM;
            end
            trs_pkg::OPC_SOB: begin
              gpr[mdata_reg[8:6]] <= sob_val;
              if (sob_val != 16'h0000) begin
                // Offset zero-extended, so the target is never forward
                gpr[trs_pkg::PC_IDX] <= pc_adv - {9'h000, mdata_reg[5:0], 1'b0};
              end
            end
            trs_pkg::OPC_SPL: begin
              if (ps_reg[trs_pkg::PS_MODE_HI:trs_pkg::PS_MODE_LO] == 2'h0) begin
                ps_reg[trs_pkg::PS_PRI_HI:trs_pkg::PS_PRI_LO] <= mdata_reg[2:0];
              end
            end
            trs_pkg::OPC_SWTRAP, trs_pkg::OPC_ILLEGAL: begin
              // Instruction trap outranks a pending trace
              vec_reg        <= dec.vector;
              last_vec_reg   <= dec.vector;
              in_trap_reg    <= 1'b1;
              trace_pend_reg <= 1'b0;
              state_reg      <= trs_pkg::S_PUSH_PS;
            end
            trs_pkg::OPC_RTI, trs_pkg::OPC_RTT: begin
              mem_out   <= rd_req(gpr[trs_pkg::SP_IDX]);
              ret_reg   <= trs_pkg::S_RET_PC;
              state_reg <= trs_pkg::S_MEM;
            end
            default: begin
              state_reg <= trs_pkg::S_EXT;
            end
          endcase
        end
        trs_pkg::S_EXT: begin
          if (ext_ready) begin
            if (ext_undefined) begin
              vec_reg        <= trs_pkg::VEC_RESVD;
              last_vec_reg   <= trs_pkg::VEC_RESVD;
              in_trap_reg    <= 1'b1;
              trace_pend_reg <= 1'b0;
              state_reg      <= trs_pkg::S_PUSH_PS;
            end else begin
              state_reg <= trs_pkg::S_END;
            end
          end
        end
        trs_pkg::S_POP_REG: begin
          // Destination written last so it wins when it is SP itself
          gpr[trs_pkg::SP_IDX] <= gpr[trs_pkg::SP_IDX] + trs_pkg::WORD_STEP;
          gpr[pop_dst_reg]     <= mdata_reg;
          state_reg            <= trs_pkg::S_END;
        end
        trs_pkg::S_RET_PC: begin
          gpr[trs_pkg::PC_IDX] <= mdata_reg;
          gpr[trs_pkg::SP_IDX] <= gpr[trs_pkg::SP_IDX] + trs_pkg::WORD_STEP;
          mem_out              <= rd_req(gpr[trs_pkg::SP_IDX] + trs_pkg::WORD_STEP);
          ret_reg              <= trs_pkg::S_RET_PS;
          state_reg            <= trs_pkg::S_MEM;
        end
        trs_pkg::S_RET_PS: begin
          ps_reg               <= mdata_reg;
          gpr[trs_pkg::SP_IDX] <= gpr[trs_pkg::SP_IDX] + trs_pkg::WORD_STEP;
          // Plain return traces at once; the inhibiting one waits an instruction
          trace_pend_reg       <= (instr_reg == trs_pkg::RTI_CODE) &&
                                  mdata_reg[trs_pkg::PS_T_BIT];
          state_reg            <= trs_pkg::S_END;
        end
        trs_pkg::S_END: begin
          if (trace_pend_reg) begin
            vec_reg        <= trs_pkg::VEC_BPT;
            last_vec_reg   <= trs_pkg::VEC_BPT;
            in_trap_reg    <= 1'b1;
            trace_pend_reg <= 1'b0;
            state_reg      <= trs_pkg::S_PUSH_PS;
          end else if (pf_pend_reg) begin
            vec_reg      <= trs_pkg::VEC_PWR;
            last_vec_reg <= trs_pkg::VEC_PWR;
            in_trap_reg  <= 1'b1;
            pf_pend_reg  <= 1'b0;
            state_reg    <= trs_pkg::S_PUSH_PS;
          end else if (run_reg) begin
            state_reg <= trs_pkg::S_FETCH;
          end else begin
            state_reg <= trs_pkg::S_IDLE;
          end
        end
        trs_pkg::S_PUSH_PS: begin
          gpr[trs_pkg::SP_IDX] <= gpr[trs_pkg::SP_IDX] - trs_pkg::WORD_STEP;
          mem_out   <= wr_req(gpr[trs_pkg::SP_IDX] - trs_pkg::WORD_STEP, ps_reg);
          ret_reg   <= trs_pkg::S_PUSH_PC;
          state_reg <= trs_pkg::S_MEM;
        end
        trs_pkg::S_PUSH_PC: begin
          gpr[trs_pkg::SP_IDX] <= gpr[trs_pkg::SP_IDX] - trs_pkg::WORD_STEP;
          mem_out   <= wr_req(gpr[trs_pkg::SP_IDX] - trs_pkg::WORD_STEP,
                              gpr[trs_pkg::PC_IDX]);
          ret_reg   <= trs_pkg::S_VEC_PC;
          state_reg <= trs_pkg::S_MEM;
        end
        trs_pkg::S_VEC_PC: begin
          mem_out   <= rd_req(vec_reg);
          ret_reg   <= trs_pkg::S_VEC_PS;
          state_reg <= trs_pkg::S_MEM;
        end
        trs_pkg::S_VEC_PS: begin
          gpr[trs_pkg::PC_IDX] <= mdata_reg;
          mem_out   <= rd_req(vec_reg + trs_pkg::WORD_STEP);
          ret_reg   <= trs_pkg::S_TRAP_DONE;
          state_reg <= trs_pkg::S_MEM;
        end
        trs_pkg::S_TRAP_DONE: begin
          ps_reg      <= mdata_reg;
          in_trap_reg <= 1'b0;
          state_reg   <= trs_pkg::S_END;
        end
        trs_pkg::S_HALT: begin
          in_trap_reg <= 1'b0;
          if (pc_wr_reg) begin
            gpr[trs_pkg::PC_IDX] <= pc_wdata_reg;
          end
          if (cont_reg) begin
            state_reg <= trs_pkg::S_IDLE;
          end
        end
        default: begin
          state_reg <= trs_pkg::S_IDLE;
        end
      endcase
      // A new power failure edge wins over the clear above
      if (pf_rise) begin
        pf_pend_reg <= 1'b1;
      end
    end
  end

endmodule : trs_sequencer

`default_nettype wire

// ==== tb/trs_sequencer_props.sv ====
// Port checker for the trap and return sequencer
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer_props #(
  parameter int BUS_TIMEOUT = 4
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire trs_pkg::trs_mem_req_t mem_out,
  input wire logic                  mem_ack,
  input wire logic [15:0]           mem_rdata,
  input wire logic                  ext_valid,
  input wire logic [15:0]           ext_instr,
  input wire logic                  ext_ready,
  input wire logic                  ext_undefined,
  input wire logic                  pwr_fail,
  input wire logic                  halted
);
  logic [15:0] last_wa;
  logic        wpar;
  int          tcnt;
  // Push parity, last push address, cycles of unanswered request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wpar    <= 1'b0;
      last_wa <= 16'h0000;
      tcnt    <= 0;
    end else begin
      tcnt <= (mem_out.req && !mem_ack) ? tcnt + 1 : 0;
      if (mem_out.req && mem_out.we && mem_ack) begin
        wpar    <= ~wpar;
        last_wa <= mem_out.addr;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence pair_done_s;
    mem_out.req && mem_out.we && mem_ack && wpar;
  endsequence
  odd_addr_a: assert property (mem_out.req |-> !mem_out.addr[0])
    else $error("odd bus address");
  timeout_cap_a: assert property (tcnt <= BUS_TIMEOUT + 1)
    else $error("request outlived timeout");
  timeout_early_a: assert property (mem_out.req && !mem_ack && tcnt + 2 < BUS_TIMEOUT
    |=> mem_out.req && $stable(mem_out.addr)) else $error("request dropped early");
  push_step_a: assert property (mem_out.req && mem_out.we && wpar
    |-> mem_out.addr == last_wa - 16'h0002) else $error("push step wrong");
  vec_fetch_a: assert property (pair_done_s |-> ##[1:6] (mem_out.req && !mem_out.we
    && mem_out.addr[15:5] == 11'h000 && mem_out.addr[1:0] == 2'b00)) else $error("no vector read");
  undef_trap_a: assert property (ext_valid && ext_ready && ext_undefined
    |-> ##[1:12] (mem_out.req && mem_out.we)) else $error("no reserved trap");
  ext_decode_a: assert property (ext_valid |-> ext_instr[15:9] != 7'h44
    && ext_instr[15:3] != 13'h0013) else $error("handled opcode passed out");
  halt_quiet_a: assert property (halted |-> !mem_out.req)
    else $error("bus used while halted");
endmodule : trs_sequencer_props
`default_nettype wire

// ==== tb/trs_mem_model.sv ====
// Memory partner with random wait states and a silent region
`timescale 1ns/1ps
`default_nettype none
module trs_mem_model (
  input  wire logic                  pclk,
  input  wire trs_pkg::trs_mem_req_t mem_out,
  output logic                       mem_ack,
  output logic [15:0]                mem_rdata
);
  logic [15:0] mem [logic [15:0]];
  int          wq [$];
  int          wait_cnt = 0;
  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 16'hA5A5;
  end
  // Answer after 0..3 waits; 8000-BFFF never answers, so those time out
  always @(posedge pclk) begin
    if (mem_ack || !mem_out.req || mem_out.addr[15:14] == 2'b10) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= $urandom_range(3);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else begin
      mem_ack <= 1'b1;
      if (mem_out.we) begin
        mem[mem_out.addr] = mem_out.wdata;
        wq.push_back(mem_out.addr);
        wq.push_back(mem_out.wdata);
      end else begin
        mem_rdata <= mem.exists(mem_out.addr) ? mem[mem_out.addr] : 16'h0000;
      end
    end
  end
endmodule : trs_mem_model
`default_nettype wire

// ==== tb/trs_sequencer_test.sv ====
// Testbench for the trap and return sequencer
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer_test;
  // Above the partner's longest wait (ack seen up to 5 edges after request)
  localparam int BUS_TIMEOUT = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, halted;
  logic ext_valid, ext_ready, ext_undefined, pwr_fail;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] mem_rdata, ext_instr, rnd;
  trs_pkg::trs_mem_req_t mem_out;
  int error_cnt = 0, num_checks = 0, ew [$];
  int tv [7] = '{24, 28, 12, 16, 4, 4, 8};
  logic [15:0] ti [7];
  trs_sequencer #(.BUS_TIMEOUT(BUS_TIMEOUT)) u_dut (.*);
  trs_mem_model u_mem (.pclk(pclk), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // Clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic int h(input int v);
    return 32'h1000 + v * 16;
  endfunction : h
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input int e, input logic [31:0] s);
    num_checks++;
    if (e >= 0 && s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic go(input logic [15:0] pc0, ins, input int un, epc, eps, ev, eh);
    logic [31:0] q;
    int n;
    u_mem.mem[pc0] = ins;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    u_mem.wq.delete();
    apb(1'b1, trs_pkg::ADDR_PC, {16'h0000, pc0}, q);
    apb(1'b1, trs_pkg::ADDR_CTRL, 32'h1, q);
    n = un;
    while (n >= 0) begin
      @(posedge pclk);
      if (halted === 1'b1 || (ext_valid === 1'b1 && n == 0)) n = -1;
      else if (ext_valid === 1'b1) begin
        {ext_ready, ext_undefined} <= 2'b11;
        @(posedge pclk);
        {ext_ready, ext_undefined} <= 2'b00;
        n = 0;
      end
    end
    chk("halted", eh, {31'h0, halted});
    if (eh == 0) chk("ext_instr", 0, {16'h0, ext_instr});
    apb(1'b0, trs_pkg::ADDR_PC, 32'h0, q);
    chk("pc", epc, q);
    apb(1'b0, trs_pkg::ADDR_PS, 32'h0, q);
    chk("ps", eps, q);
    apb(1'b0, trs_pkg::ADDR_STATUS, 32'h0, q);
    chk("vector", ev, {24'h0, q[7:0]});
    chk("writes", ew.size(), u_mem.wq.size());
    foreach (ew[i]) if (i < u_mem.wq.size()) chk("stack", ew[i], u_mem.wq[i]);
    ew.delete();
    $display("test at %h done", pc0);
  endtask : go
  // Cut a hang short
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_ready, ext_undefined, pwr_fail} = 3'b000;
    rnd = $urandom(71);
    for (int v = 4; v <= 28; v += 4) begin
      u_mem.mem[v] = h(v);
      u_mem.mem[v + 2] = v << 8;
      u_mem.mem[h(v)] = 16'h0000;
    end
    ti = '{16'h8800 | 16'($urandom % 256), 16'h89FF, 16'h0003, 16'h0004, 16'h0043, 16'h0943, 16'h0007};
    foreach (tv[i]) begin
      ew = '{16'hFFFE, 0, 16'hFFFC, 16'h0102};
      go(16'h0100, ti[i], i == 6, h(tv[i]) + 2, tv[i] << 8, tv[i], 0);
    end
    ew = '{16'hFFFE, 0, 16'hFFFC, -1};
    go(16'h0101, 16'h0000, 0, h(4) + 2, 16'h0400, 4, 0);
    ew = '{16'hFFFE, 0, 16'hFFFC, -1};
    go(16'h8000, 16'h0000, 0, h(4) + 2, 16'h0400, 4, 0);
    u_mem.mem[16'h0102] = 16'h0000;
    go(16'h0100, 16'h009D, 0, 16'h0104, 16'h00A0, 0, 0);
    // Power failure held through reset: trap taken after the first instruction
    pwr_fail <= 1'b1;
    ew = '{16'hFFFE, 16'h00A0, 16'hFFFC, 16'h0102};
    go(16'h0100, 16'h009D, 0, h(20) + 2, 16'h1400, 20, 0);
    pwr_fail <= 1'b0;
    u_mem.mem[16'h0000] = 16'h0300;
    u_mem.mem[16'h0300] = 16'h0000;
    go(16'h0100, 16'h0087, 0, 16'h0302, 0, 0, 0);
    u_mem.mem[16'h0084] = 16'h0000;
    go(16'h0100, 16'h7EBF, 0, 16'h0086, 0, 0, 0);
    u_mem.mem[16'h0000] = 16'h0000;
    go(16'h0100, 16'h0D03, 0, 16'h0002, 0, 0, 0);
    u_mem.mem[16'h0000] = 16'h0300;
    u_mem.mem[16'h0002] = 16'h0011;
    // Inhibiting return: no trace trap before the next instruction runs
    go(16'h0100, 16'h0006, 0, 16'h0302, 16'h0011, 0, 0);
    ew = '{2, 16'h0011, 0, 16'h0300};
    go(16'h0100, 16'h0002, 0, h(12) + 2, 16'h0C00, 12, 0);
    go(16'h7FF0, 16'h0D3F, 0, -1, -1, -1, 1);
    close_out();
  end
endmodule : trs_sequencer_test
bind trs_sequencer trs_sequencer_props #(.BUS_TIMEOUT(BUS_TIMEOUT)) u_props (.*);
`default_nettype wire
